// *** rtl/dpba_arbiter.sv ***
`timescale 1ns/1ps
module dpba_arbiter
  import dpba_pkg::*;
(
  input wire logic sys_clk_i,                 // System clock 100 MHz
  input wire logic rst_n_i,                   // Async reset, active low
  input wire logic [15:0] host_addr_i,        // Host low address
  input wire logic [7:0] host_addr_hi_i,      // Host upper address
  input wire logic [5:0] host_am_i,           // Host address modifier
  input wire logic strobe_lane_zero_n_i,      // Host data strobe 0
  input wire logic strobe_lane_one_n_i,       // Host data strobe 1
  input wire logic host_write_i,              // Host write direction
  input wire logic [7:0] host_data_i,         // Host data low lane in
  input wire logic ack_chain_input_n_i,       // Acknowledge daisy chain in
  input wire logic [2:0] ack_level_i,         // Acknowledged level
  input wire logic ack_address_modifier_i,    // Acknowledge modifier seen
  input wire logic module_irq_pending_i,      // This module raised interrupt
  input wire logic ctrl_dma_in_req_n_i,       // Controller DMA input request
  input wire logic ctrl_dma_out_req_n_i,      // Controller DMA output request
  input wire logic [15:0] ctrl_addr_i,        // Controller DMA address
  output logic [7:0] host_data_o,             // Host data low lane out
  output logic host_data_oe_o,                // Host data drive enable
  output logic [7:0] local_data_o,            // Local data from host
  output logic local_data_oe_o,               // Local data drive enable
  output logic buffer_drive_low_o,            // Buffer enable toward host
  output logic module_select_o,               // Module selected
  output logic ctrl_bus_grant_o,              // Controller owns local bus
  output logic host_bus_grant_o,              // Host owns local bus
  output logic ctrl_clk_o,                    // Controller 2 MHz clock
  output logic cycle_done_o,                  // End of cycle pulse
  output logic dma_dir_out_o,                 // Latched DMA direction
  output dpba_local_t local_o                 // Local bus controls
);
  // Input synchronisers (two flops each)
  logic [7:0] s1, s2;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 8'hff;
      s2 <= 8'hff;
    end else begin
      s1 <= {strobe_lane_zero_n_i, strobe_lane_one_n_i, ack_chain_input_n_i,
             ctrl_dma_in_req_n_i, ctrl_dma_out_req_n_i, ~ack_address_modifier_i,
             ~module_irq_pending_i, ~host_write_i};
      s2 <= s1;
    end
  end
  wire ds0_n = s2[7];
  wire ds1_n = s2[6];
  wire ack_n = s2[5];
  wire dma_in_n = s2[4];
  wire dma_out_n = s2[3];
  wire am_ack = ~s2[2];
  wire irq_pend = ~s2[1];
  wire hwrite = ~s2[0];

  // Fast clock tick and controller clock divider
  logic [3:0] fdiv;
  logic [2:0] cdiv;
  logic fast_tick;
  wire next_tick = (fdiv == FAST_DIV_LAST);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fdiv <= 4'h0;
      fast_tick <= 1'b0;
      cdiv <= 3'h0;
      ctrl_clk_o <= 1'b0;
    end else begin
      fdiv <= next_tick ? 4'h0 : fdiv + 4'h1;
      fast_tick <= next_tick;
      if (fast_tick) begin
        cdiv <= (cdiv == CTRL_HALF_LAST) ? 3'h0 : cdiv + 3'h1;
        if (cdiv == CTRL_HALF_LAST) ctrl_clk_o <= ~ctrl_clk_o;
      end
    end
  end

  // Module select and requests
  wire sel_match = (host_addr_hi_i == MOD_BASE) && (host_am_i == MOD_AM)
                   && !ds0_n && !ds1_n;
  wire ack_sel = !ack_n && (ack_level_i == IRQ_LEVEL) && am_ack && irq_pend;
  wire host_req = sel_match || ack_sel;
  wire ctrl_req = !(dma_in_n && dma_out_n);
  wire idle_n = host_req || ctrl_req;

  // Arbitration state
  dpba_state_t state;
  logic host_win, deskew;
  logic [CHAIN_LEN-1:0] chain;
  logic [4:0] guard;
  wire at_t1 = chain[T_SETUP];
  wire cyc_end = host_win ? chain[T_HOST_DONE] : chain[T_CTRL_DONE];
  wire guard_end = (guard == GUARD_LAST);
  // Host wins a tie unless it won the previous cycle, for fairness
  logic prefer_ctrl;
  wire next_host_win = host_req && !(ctrl_req && prefer_ctrl);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= DPBA_IDLE;
      host_win <= 1'b0;
      prefer_ctrl <= 1'b0;
      chain <= '0;
      guard <= 5'h0;
      deskew <= 1'b0;
      dma_dir_out_o <= 1'b0;
    end else if (fast_tick) begin
      deskew <= ack_sel;
      chain <= {chain[CHAIN_LEN-2:0], 1'b0};
      unique case (state)
        DPBA_IDLE: begin
          host_win <= next_host_win;
          dma_dir_out_o <= !dma_out_n;
          if (idle_n && (!ack_sel || deskew)) begin
            state <= DPBA_CYCLE;
            chain <= {{(CHAIN_LEN-1){1'b0}}, 1'b1};
          end
        end
        DPBA_CYCLE: if (cyc_end) begin
          state <= DPBA_GUARD;
          guard <= 5'h0;
        end
        DPBA_GUARD: begin
          guard <= guard + 5'h1;
          if (guard_end) state <= DPBA_DONE;
        end
        DPBA_DONE: begin
          state <= DPBA_IDLE;
          prefer_ctrl <= host_win;
        end
      endcase
    end
  end

  // Bus ownership during the cycle
  wire in_cycle = (state == DPBA_CYCLE);
  wire hg = in_cycle && host_win;
  wire cg = in_cycle && !host_win;

  // Address routing and register window
  wire is_reg = (local_o.addr < REG_SPAN);
  wire [15:0] next_addr = hg ? host_addr_i : ctrl_addr_i;
  wire next_reg = (next_addr < REG_SPAN);

  // Host transfer kinds
  wire host_ack_rd = hg && ack_sel;
  wire host_rd = hg && !hwrite;
  wire host_wr = hg && hwrite && !ack_sel;

  // Write strobe windows; controller output transfers write the RAM
  wire wr_win = chain[T_WR_BEGIN] | chain[3] | chain[4] | chain[5] | chain[6];
  wire next_ctrl_we = cg && dma_dir_out_o && wr_win;
  wire next_host_we = host_wr && (chain[T_SETUP+1] | chain[3] | chain[4] | chain[5]);

  // Registered outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_data_o <= 8'h00;
      host_data_oe_o <= 1'b0;
      local_data_o <= 8'h00;
      local_data_oe_o <= 1'b0;
      buffer_drive_low_o <= 1'b0;
      module_select_o <= 1'b0;
      host_bus_grant_o <= 1'b0;
      ctrl_bus_grant_o <= 1'b0;
      cycle_done_o <= 1'b0;
      local_o <= '{addr: 16'h0000, ram_ce_n: 1'b1, ram_we_n: 1'b1,
                   reg_cs_n: 1'b1, reg_we_n: 1'b1};
    end else begin
      module_select_o <= sel_match;
      host_bus_grant_o <= hg;
      ctrl_bus_grant_o <= cg;
      cycle_done_o <= fast_tick && (state == DPBA_DONE);
      host_data_o <= host_ack_rd ? IRQ_VECTOR : 8'h00;
      host_data_oe_o <= host_rd || host_ack_rd;
      buffer_drive_low_o <= host_rd || host_ack_rd;
      local_data_o <= host_data_i;
      local_data_oe_o <= host_wr;
      local_o.addr <= next_addr;
      local_o.ram_ce_n <= !(in_cycle && !next_reg && (next_addr < RAM_TOP));
      local_o.ram_we_n <= !(next_ctrl_we || (next_host_we && !next_reg));
      local_o.reg_cs_n <= !(hg && next_reg && (at_t1 || !local_o.reg_cs_n)
                            && !chain[T_HOST_DONE]);
      local_o.reg_we_n <= !(next_host_we && next_reg);
    end
  end

  // Cycles since the controller last held the bus, saturating
  logic [5:0] ctrl_quiet;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_quiet <= 6'h3f;
    end else if (ctrl_bus_grant_o) begin
      ctrl_quiet <= 6'h00;
    end else if (ctrl_quiet != 6'h3f) begin
      ctrl_quiet <= ctrl_quiet + 6'h1;
    end
  end

  // Assertions
  a_grant_excl: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(host_bus_grant_o && ctrl_bus_grant_o))
    else $error("both grants active");
  a_done_width: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cycle_done_o |=> !cycle_done_o)
    else $error("done pulse too wide");
  a_reg_ram_split: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !local_o.reg_cs_n |-> local_o.ram_ce_n && is_reg)
    else $error("ram and register selected together");
  a_cs_host_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !local_o.reg_cs_n |-> $past(host_win))
    else $error("register select without host");
  a_we_with_cs: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(local_o.reg_we_n) |-> local_data_oe_o || !local_o.reg_cs_n || $past(local_data_oe_o))
    else $error("write strobe outlived data");
  a_dir_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == DPBA_CYCLE) && $past(state == DPBA_CYCLE) |-> $stable(dma_dir_out_o))
    else $error("direction changed in cycle");
  a_guard_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == DPBA_DONE) |-> guard == GUARD_LAST + 5'h1)
    else $error("guard delay short");
  a_latch_frozen: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state != DPBA_IDLE) && $past(state != DPBA_IDLE) |-> $stable(host_win))
    else $error("grant changed mid cycle");
  a_vector_ack: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    host_data_oe_o && $past(host_ack_rd) |-> host_data_o == IRQ_VECTOR)
    else $error("wrong vector");

  // Grant and cycle sequencing
  a_dma_host_gap: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(host_bus_grant_o) |-> ctrl_quiet >= GUARD_SYS_MIN)
    else $error("host grant too soon after controller");
  a_done_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cycle_done_o |-> state == DPBA_IDLE)
    else $error("done pulse outside idle");
  a_chain_onehot: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $onehot0(chain))
    else $error("timing chain not one-hot");
  a_chain_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(state == DPBA_CYCLE) |-> chain[0])
    else $error("cycle began without chain start");

  // Data buffer direction
  a_host_oe_grant: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    host_data_oe_o |-> host_bus_grant_o)
    else $error("host buffer on without host grant");
  a_local_oe_grant: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    local_data_oe_o |-> host_bus_grant_o)
    else $error("local buffer on without host grant");
  a_oe_excl: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(host_data_oe_o && local_data_oe_o))
    else $error("both buffer directions on");
  a_vector_src: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    host_data_oe_o && host_data_o == IRQ_VECTOR |-> $past(ack_sel))
    else $error("vector without qualified acknowledge");

  // Address and select paths
  a_host_addr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    host_bus_grant_o |-> local_o.addr == $past(host_addr_i))
    else $error("host address not on local bus");
  a_ctrl_addr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ctrl_bus_grant_o |-> local_o.addr == $past(ctrl_addr_i))
    else $error("controller address not on local bus");
  a_sel_modifier: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    module_select_o |-> $past(host_am_i) == MOD_AM)
    else $error("select without modifier match");

  // Strobe timing
  a_we_in_cs: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !local_o.reg_we_n |-> !local_o.reg_cs_n)
    else $error("register write strobe without select");
  a_cs_after_t1: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(local_o.reg_cs_n) |-> $past(at_t1))
    else $error("register select before set-up pulse");
  a_ctrl_we_dir: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !local_o.ram_we_n && ctrl_bus_grant_o |-> dma_dir_out_o)
    else $error("ram write on controller input transfer");
endmodule : dpba_arbiter

// *** rtl/dpba_pkg.sv ***
package dpba_pkg;
  // Fast clock and derived rates
  localparam int SYS_CLK_MHZ = 100;
  localparam int FAST_CLK_MHZ = 16;
  localparam int CTRL_CLK_MHZ = 2;
  // Fast clock tick divider: 100 MHz / 16 MHz, rounded down to whole cycles
  localparam int FAST_DIV = SYS_CLK_MHZ / FAST_CLK_MHZ;
  localparam logic [3:0] FAST_DIV_LAST = 4'(FAST_DIV - 1);
  // Controller clock toggles every FAST_CLK/(2*CTRL_CLK) ticks
  localparam int CTRL_HALF = FAST_CLK_MHZ / (2 * CTRL_CLK_MHZ);
  localparam logic [2:0] CTRL_HALF_LAST = 3'(CTRL_HALF - 1);
  // Timing chain length and pulse positions (in fast ticks)
  localparam int CHAIN_LEN = 16;
  localparam int T_SETUP = 1;
  localparam int T_WR_BEGIN = 2;
  localparam int T_HOST_DONE = 7;
  localparam int T_WR_END = 7;
  localparam int T_CTRL_DONE = 10;
  // Guard delay: least time 500 ns in real fast ticks, rounded up
  localparam int GUARD_NS = 500;
  localparam int FAST_PERIOD_PS = FAST_DIV * (1000000 / SYS_CLK_MHZ);
  localparam int GUARD_TICKS = (GUARD_NS * 1000 + FAST_PERIOD_PS - 1) / FAST_PERIOD_PS;
  localparam logic [4:0] GUARD_LAST = 5'(GUARD_TICKS - 1);
  // Same least time in system clock cycles
  localparam logic [5:0] GUARD_SYS_MIN = 6'(GUARD_NS * SYS_CLK_MHZ / 1000);
  // Address decoding
  localparam logic [15:0] REG_SPAN = 16'h0010;
  localparam logic [15:0] RAM_TOP = 16'h2000;
  localparam logic [7:0] IRQ_VECTOR = 8'hff;
  localparam logic [2:0] IRQ_LEVEL = 3'h4;
  // Module select match values (arbitrary board strap)
  localparam logic [7:0] MOD_BASE = 8'h00;
  localparam logic [5:0] MOD_AM = 6'h3d;

  typedef enum logic [1:0] {
    DPBA_IDLE  = 2'b00,
    DPBA_CYCLE = 2'b01,
    DPBA_GUARD = 2'b10,
    DPBA_DONE  = 2'b11
  } dpba_state_t;

  // Local bus drive group
  typedef struct packed {
    logic [15:0] addr;
    logic ram_ce_n;
    logic ram_we_n;
    logic reg_cs_n;
    logic reg_we_n;
  } dpba_local_t;
endpackage : dpba_pkg

// *** verification/dpba_arbiter_tb_top.sv ***
`timescale 1ns/1ps
module dpba_arbiter_tb_top;
  import dpba_pkg::*;
  logic sys_clk_i = 0, rst_n_i = 0, ds_n = 1, wr = 0, ack_n = 1, ack_am = 0, irq = 0;
  logic go = 0, go_out = 0, in_n, out_n, hg, cg, done, dir, oe, loe, bdl, ms, cclk;
  logic cclk_q = 0;
  logic [15:0] haddr = '0, caddr;
  logic [7:0] hhi = 8'hff, hdat = 8'h5a, hout, lout;
  logic [5:0] ham = '0;
  logic [2:0] lvl = '0;
  logic [9:0] seen = '0;
  dpba_local_t lo;
  int err_count = 0, cmp_count = 0, cyc = 0, glen = 0, gap = 0, tog = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  dpba_ctrl_model u_ctrl (.req_i(go), .out_i(go_out), .grant_i(cg), .in_req_n_o(in_n),
    .out_req_n_o(out_n), .addr_o(caddr));
  dpba_arbiter u_dut (.sys_clk_i, .rst_n_i, .host_addr_i(haddr), .host_addr_hi_i(hhi),
    .host_am_i(ham), .strobe_lane_zero_n_i(ds_n), .strobe_lane_one_n_i(ds_n),
    .host_write_i(wr), .host_data_i(hdat), .ack_chain_input_n_i(ack_n),
    .ack_level_i(lvl), .ack_address_modifier_i(ack_am), .module_irq_pending_i(irq),
    .ctrl_dma_in_req_n_i(in_n), .ctrl_dma_out_req_n_i(out_n), .ctrl_addr_i(caddr),
    .host_data_o(hout), .host_data_oe_o(oe), .local_data_o(lout), .local_data_oe_o(loe),
    .buffer_drive_low_o(bdl), .module_select_o(ms), .ctrl_bus_grant_o(cg),
    .host_bus_grant_o(hg), .ctrl_clk_o(cclk), .cycle_done_o(done), .dma_dir_out_o(dir),
    .local_o(lo));
  // Watch outputs; bits: bufdrv dirout caddr ldata vec ramwe ramce regwe regcs both
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
    tog += 32'(cclk !== cclk_q);
    cclk_q = cclk;
    glen += 32'(hg | cg);
    gap = (hg | cg) ? 0 : gap + 1;
    seen |= {oe & bdl & ~wr, cg & dir, cg & (lo.addr === 16'h0800), loe & (lout === hdat),
      oe & (hout === IRQ_VECTOR), ~lo.ram_we_n, ~lo.ram_ce_n, ~lo.reg_we_n, ~lo.reg_cs_n,
      hg & cg};
  end
  task automatic chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Wait for the end pulse, withdraw requests, then check it lasted one cycle
  task automatic wait_done(input int ticks);
    int n;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("done", 10'(done), 10'h1);
    chk("guard", 10'(gap * (1000 / SYS_CLK_MHZ) >= GUARD_NS), 10'h1);
    chk("len", 10'(glen >= (ticks - 1) * FAST_DIV && glen <= (ticks + 1) * FAST_DIV), 10'h1);
    ds_n = 1;
    ack_n = 1;
    go = 0;
    hhi = 8'hff;
    @(negedge sys_clk_i);
    chk("done_width", 10'(done), 10'h0);
    repeat (30) @(negedge sys_clk_i);
  endtask : wait_done
  task automatic host(input logic [15:0] a, input logic w);
    @(negedge sys_clk_i);
    seen = '0;
    glen = 0;
    haddr = a;
    wr = w;
    hhi = MOD_BASE;
    ham = MOD_AM;
    ds_n = 0;
    repeat (4) @(negedge sys_clk_i);
    chk("select", 10'(ms), 10'h1);
    wait_done(T_HOST_DONE);
  endtask : host
  task automatic t_reg();
    host(16'h000f, 1);
    chk("reg_write", seen, 10'h046);
  endtask : t_reg
  task automatic t_ram();
    host(16'h0010, 0);
    chk("ram_read", seen, 10'h208);
  endtask : t_ram
  task automatic t_dma(input logic o);
    @(negedge sys_clk_i);
    seen = '0;
    glen = 0;
    go_out = o;
    go = 1;
    wait_done(T_CTRL_DONE);
    chk("dma", seen & 10'h19b, o ? 10'h198 : 10'h088);
  endtask : t_dma
  task automatic t_ack();
    @(negedge sys_clk_i);
    seen = '0;
    glen = 0;
    lvl = IRQ_LEVEL;
    ack_am = 1;
    irq = 1;
    ack_n = 0;
    ds_n = 0;
    wr = 0;
    repeat (4) @(negedge sys_clk_i);
    chk("ack_select", 10'(ms), 10'h0);
    wait_done(T_HOST_DONE);
    chk("vector", seen & 10'h021, 10'h020);
  endtask : t_ack
  task automatic t_clk();
    tog = 0;
    repeat (480) @(negedge sys_clk_i);
    chk("ctrl_clk", 10'(tog >= 19 && tog <= 21), 10'h1);
  endtask : t_clk
  task automatic t_tie();
    @(negedge sys_clk_i);
    seen = '0;
    glen = 0;
    go_out = 1;
    go = 1;
    haddr = 16'h0200;
    hhi = MOD_BASE;
    ham = MOD_AM;
    ds_n = 0;
    // Host won the previous cycle, so the controller takes this tie
    wait_done(T_CTRL_DONE);
    chk("both", seen & 10'h081, 10'h080);
  endtask : t_tie
  task automatic end_sim();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_n_i = 1;
    repeat (4) @(negedge sys_clk_i);
    t_clk();
    t_reg();
    t_ram();
    t_dma(1);
    t_dma(0);
    t_ack();
    t_tie();
    end_sim();
  end
endmodule : dpba_arbiter_tb_top

// *** verification/dpba_ctrl_model.sv ***
`timescale 1ns/1ps
module dpba_ctrl_model (
  input wire logic req_i,     // Bench asks for a DMA transfer
  input wire logic out_i,     // Direction, high for output
  input wire logic grant_i,   // Local bus granted to controller
  output logic in_req_n_o,    // DMA input request
  output logic out_req_n_o,   // DMA output request
  output logic [15:0] addr_o  // DMA address
);
  // Request levels held until the bench withdraws them
  assign in_req_n_o = ~(req_i & ~out_i);
  assign out_req_n_o = ~(req_i & out_i);
  // Address valid only while granted, inverted otherwise
  assign addr_o = grant_i ? 16'h0800 : 16'hf7ff;
endmodule : dpba_ctrl_model
